// File: hw/pbs_pkg.sv
// Shared constants and types of the push-button power sequencer.
package pbs_pkg;
    localparam int CLK_FREQ_MHZ = 100;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES_DEF = TICK_US * CLK_FREQ_MHZ;
    localparam int PRESC_W = 17;
    localparam int SEQ_W = 8;
    localparam int RAIL1_DELAY_MS = 2;
    localparam int RAIL2_DELAY_MS = 4;
    localparam logic [SEQ_W-1:0] RAIL1_TICKS = SEQ_W'(RAIL1_DELAY_MS * 1000 / TICK_US);
    localparam logic [SEQ_W-1:0] RAIL2_TICKS = SEQ_W'(RAIL2_DELAY_MS * 1000 / TICK_US);
    localparam logic [SEQ_W-1:0] RESET_TICKS_DEF = 8'h40;
    localparam logic [SEQ_W-1:0] DEBOUNCE_TICKS_DEF = 8'h08;
    localparam int NUM_RAILS = 7;
    localparam int RAIL1 = 0;
    localparam int RAIL2 = 1;
    localparam int RAIL3 = 2;
    localparam logic [NUM_RAILS-1:0] AUX_RAILS = 7'h78;
    localparam logic [NUM_RAILS-1:0] MAIN_RAILS = 7'h07;
    localparam logic [NUM_RAILS-1:0] RAIL1_ONLY = 7'h01;
    localparam int IN_PG_LSB = 0;
    localparam int IN_HOLD = 7;
    localparam int IN_AUX = 8;
    localparam int IN_SYS = 9;
    localparam int IN_STANDBY_VOLTAGE_SELECT = 10;
    localparam int IN_W = 11;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_UNMASK = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam int CTRL_FORCE_BIT = 0;
    localparam int CTRL_HIB_BIT = 1;
    localparam int UNMASK_SYS_BIT = 0;
    localparam int UNMASK_FLT_BIT = 1;
    localparam int STAT_SYS_BIT = 0;
    localparam int STAT_FLT_BIT = 1;
    localparam int STAT_BTN_BIT = 2;
    localparam int STAT_RST_BIT = 3;
    localparam int STAT_RAIL_LSB = 8;
    localparam int STAT_STATE_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {ST_OFF, ST_RAMP, ST_SEQ, ST_RUN, ST_HIB} pbs_state_e;
endpackage

// File: hw/pbs_debounce.sv
// Two-flop synchroniser and tick-based bounce filter for an active-low button pin.
`timescale 1ns/100ps
`default_nettype none
module pbs_debounce
    import pbs_pkg::*;
#(
    parameter logic [SEQ_W-1:0] STABLE_TICKS = DEBOUNCE_TICKS_DEF
) (
    input wire logic mclk, // System clock.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic tick, // Timebase pulse.
    input wire logic raw_n, // Pin, low when pressed.
    output logic sync_o, // Synchronised press, high while pressed.
    output logic stable_o // Filtered press, high while pressed.
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic stable;
        logic [SEQ_W-1:0] cnt;
    } pbs_deb_s;

    pbs_deb_s q, d;

    always_comb begin
        d = q;
        d.s1 = ~raw_n;
        d.s2 = q.s1;
        if (q.s2 == q.stable) begin
            d.cnt = '0;
        end else if (tick) begin
            if (q.cnt == STABLE_TICKS - 8'h01) begin
                d.stable = q.s2;
                d.cnt = '0;
            end else begin
                d.cnt = q.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.s2;
    assign stable_o = q.stable;
endmodule
`default_nettype wire

// File: hw/pbs_sequencer.sv
// Push-button power sequencer with AXI4-Lite control registers.
// Notes on behaviour
// - Hard press forces CPU reset low immediately.
// - Button status pulls low while pressed.
// - Startup reset times out after rail three good.
// - Interrupt pulls low on any unmasked condition.
// - Interrupt sources reset masked, unmasked individually.
// - Release without hold aborts boot, rails off.
// - Button and hold rails 1-3; aux 4-7.
// - Press enables rail three, reset on good.
// - Rails one, two follow at 2, 4 ms.
// - Reset releases only while rail three good.
// - Millisecond timebase keeps delays inside tolerance.
// - Hold or aux keeps system powered.
// - Dropping aux then hold shuts down.
// - Sleep: aux off, hold on, standby select.
// - Wake: aux on, standby select lowered.
// - Hibernate keeps only rail one on.
// - Press in hibernate wakes rails one, three.
// - Force bit keeps rail one on.
// - Series-resistor press differs from direct short.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module pbs_sequencer
    import pbs_pkg::*;
#(
    parameter logic [PRESC_W-1:0] TICK_CYCLES = PRESC_W'(TICK_CYCLES_DEF),
    parameter logic [SEQ_W-1:0] RESET_TICKS = RESET_TICKS_DEF,
    parameter logic [SEQ_W-1:0] DEBOUNCE_TICKS = DEBOUNCE_TICKS_DEF
) (
    input wire logic mclk, // System clock, 100 MHz.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    output logic [1:0] s_axi_bresp, // Write response.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    input wire logic push_button_in_n, // Button pressed through either path, low.
    input wire logic push_button_short_n, // Button shorted hard to ground, low.
    input wire logic main_rail_hold, // Processor hold of rails one to three.
    input wire logic aux_rail_enable, // Processor enable of rails four to seven.
    input wire logic standby_voltage_select, // Standby voltage request.
    input wire logic [NUM_RAILS-1:0] rail_pgood, // Power-good of rails one to seven.
    input wire logic sys_voltage_low, // System voltage below threshold.
    output logic [NUM_RAILS-1:0] rail_enable, // Regulator enables, rail one in bit 0.
    output logic standby_select_out, // Standby level request to rails one to three.
    output logic cpu_reset_out_o, // Open-drain reset level, always low.
    output logic cpu_reset_out_oe, // Reset pulled low when high.
    output logic button_status_out_o, // Open-drain status level, always low.
    output logic button_status_out_oe, // Status pulled low when high.
    output logic interrupt_request_out_o, // Open-drain interrupt level, always low.
    output logic interrupt_request_out_oe // Interrupt pulled low when high.
);
    typedef struct packed {
        logic [IN_W-1:0] sync1;
        logic [IN_W-1:0] sync2;
        logic [PRESC_W-1:0] presc;
        logic tick;
        pbs_state_e state;
        logic wake;
        logic [SEQ_W-1:0] seq;
        logic rst_low;
        logic [SEQ_W-1:0] rst_cnt;
        logic [NUM_RAILS-1:0] rail_en;
        logic force_on;
        logic hib_rdy;
        logic [1:0] unmask;
        logic irq;
        logic btn;
        logic aw_have;
        logic [ADDR_W-1:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } pbs_sq_s;

    pbs_sq_s q, d;
    logic pb_sync, pb_stable, short_sync;
    logic hold, aux, pg3, sys_low, fault;

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        addr_known = (a == ADDR_CTRL) || (a == ADDR_UNMASK) || (a == ADDR_STATUS);
    endfunction

    function automatic logic [NUM_RAILS-1:0] rail_bit(input int idx);
        rail_bit = NUM_RAILS'(1) << idx;
    endfunction

    pbs_debounce #(
        .STABLE_TICKS(DEBOUNCE_TICKS)
    ) u_button (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(q.tick),
        .raw_n(push_button_in_n),
        .sync_o(pb_sync),
        .stable_o(pb_stable)
    );

    // The short path is read raw after the flops so manual reset acts at once.
    pbs_debounce #(
        .STABLE_TICKS(DEBOUNCE_TICKS)
    ) u_short (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(q.tick),
        .raw_n(push_button_short_n),
        .sync_o(short_sync),
        .stable_o()
    );

    assign hold = q.sync2[IN_HOLD];
    assign aux = q.sync2[IN_AUX];
    assign sys_low = q.sync2[IN_SYS];
    assign pg3 = q.sync2[IN_PG_LSB + RAIL3];
    assign fault = (q.state == ST_RUN) && |(q.rail_en & ~q.sync2[IN_PG_LSB +: NUM_RAILS]);

    always_comb begin
        d = q;
        d.sync1 = {standby_voltage_select, sys_voltage_low, aux_rail_enable, main_rail_hold, rail_pgood};
        d.sync2 = q.sync1;
        // Free-running millisecond timebase; its unknown phase costs at most one tick.
        if (q.presc == TICK_CYCLES - 17'h00001) begin
            d.presc = '0;
            d.tick = 1'b1;
        end else begin
            d.presc = q.presc + 17'h00001;
            d.tick = 1'b0;
        end

        case (q.state)
            ST_OFF: begin
                d.rail_en = '0;
                if (pb_stable) begin
                    d.state = ST_RAMP;
                    d.wake = 1'b0;
                end
            end
            ST_HIB: begin
                d.rail_en = RAIL1_ONLY;
                if (pb_stable) begin
                    d.state = ST_RAMP;
                    d.wake = 1'b1;
                end
            end
            ST_RAMP: begin
                d.rail_en = rail_bit(RAIL3) | ((q.wake || q.force_on) ? RAIL1_ONLY : '0);
                d.seq = '0;
                if (!pb_stable && !hold) begin
                    d.state = q.force_on ? ST_HIB : ST_OFF;
                    d.rail_en = q.force_on ? RAIL1_ONLY : '0;
                end else if (pg3) begin
                    d.state = ST_SEQ;
                end
            end
            ST_SEQ: begin
                if (q.tick && q.seq != RAIL2_TICKS) begin
                    d.seq = q.seq + 8'h01;
                end
                d.rail_en = rail_bit(RAIL3) | (aux ? AUX_RAILS : '0);
                if (q.wake || q.force_on || q.seq >= RAIL1_TICKS) begin
                    d.rail_en = d.rail_en | RAIL1_ONLY;
                end
                if (q.seq >= RAIL2_TICKS) begin
                    d.rail_en = d.rail_en | rail_bit(RAIL2);
                end
                if (!pb_stable && !hold) begin
                    d.state = q.force_on ? ST_HIB : ST_OFF;
                    d.rail_en = q.force_on ? RAIL1_ONLY : '0;
                end else if (q.seq == RAIL2_TICKS) begin
                    d.state = ST_RUN;
                end
            end
            ST_RUN: begin
                d.rail_en = ((pb_stable || hold || aux) ? MAIN_RAILS : '0) | (aux ? AUX_RAILS : '0);
                if (q.force_on) begin
                    d.rail_en = d.rail_en | RAIL1_ONLY;
                end
                if (!pb_stable && !hold && !aux) begin
                    d.state = q.force_on ? ST_HIB : ST_OFF;
                    d.rail_en = q.force_on ? RAIL1_ONLY : '0;
                end
            end
            default: begin
                d.state = ST_OFF;
                d.rail_en = '0;
            end
        endcase

        // Reset stays low while unpowered, ramping, shorted or rail three not good.
        if (q.state == ST_OFF || q.state == ST_HIB || q.state == ST_RAMP || short_sync || !pg3) begin
            d.rst_low = 1'b1;
            d.rst_cnt = '0;
        end else if (q.rst_low && q.tick) begin
            if (q.rst_cnt == RESET_TICKS - 8'h01) begin
                d.rst_low = 1'b0;
            end else begin
                d.rst_cnt = q.rst_cnt + 8'h01;
            end
        end

        d.btn = pb_sync;
        d.irq = (sys_low && q.unmask[UNMASK_SYS_BIT]) || (fault && q.unmask[UNMASK_FLT_BIT]);

        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb0 = s_axi_wstrb[0];
        end
        if (q.aw_have && q.w_have) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = addr_known(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (q.wstrb0 && q.awaddr == ADDR_CTRL) begin
                d.force_on = q.wdata[CTRL_FORCE_BIT];
                d.hib_rdy = q.wdata[CTRL_HIB_BIT];
            end
            if (q.wstrb0 && q.awaddr == ADDR_UNMASK) begin
                d.unmask = {q.wdata[UNMASK_FLT_BIT], q.wdata[UNMASK_SYS_BIT]};
            end
        end else if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            d.rdata = '0;
            case (s_axi_araddr)
                ADDR_CTRL: begin
                    d.rdata[CTRL_FORCE_BIT] = q.force_on;
                    d.rdata[CTRL_HIB_BIT] = q.hib_rdy;
                end
                ADDR_UNMASK: begin
                    d.rdata[UNMASK_SYS_BIT] = q.unmask[UNMASK_SYS_BIT];
                    d.rdata[UNMASK_FLT_BIT] = q.unmask[UNMASK_FLT_BIT];
                end
                ADDR_STATUS: begin
                    d.rdata[STAT_SYS_BIT] = sys_low;
                    d.rdata[STAT_FLT_BIT] = fault;
                    d.rdata[STAT_BTN_BIT] = pb_stable;
                    d.rdata[STAT_RST_BIT] = q.rst_low;
                    d.rdata[STAT_RAIL_LSB +: NUM_RAILS] = q.rail_en;
                    d.rdata[STAT_STATE_LSB +: 3] = q.state;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.rst_low <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = !q.aw_have && !q.bvalid;
    assign s_axi_wready = !q.w_have && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign rail_enable = q.rail_en;
    assign standby_select_out = q.sync2[IN_STANDBY_VOLTAGE_SELECT];
    assign cpu_reset_out_o = 1'b0;
    assign cpu_reset_out_oe = q.rst_low;
    assign button_status_out_o = 1'b0;
    assign button_status_out_oe = q.btn;
    assign interrupt_request_out_o = 1'b0;
    assign interrupt_request_out_oe = q.irq;

    manual_reset_a: assert property (@(posedge mclk) disable iff (sys_rst)
        short_sync |=> cpu_reset_out_oe [*2])
        else $error("Reset not held during hard press.");

    button_status_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ##1 button_status_out_oe == $past(pb_sync))
        else $error("Button status does not follow the button.");

    startup_reset_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (q.state == ST_RAMP && d.state == ST_SEQ) |=> cpu_reset_out_oe)
        else $error("Reset released before its timeout.");

    irq_masked_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (q.unmask == 2'b00) [*2] |-> !interrupt_request_out_oe)
        else $error("Masked source raised the interrupt.");

    boot_abort_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (q.state == ST_SEQ && !pb_stable && !hold && !q.force_on) |=> q.state == ST_OFF && rail_enable == '0)
        else $error("Boot not aborted on early release.");

    rail_two_delay_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ($rose(rail_enable[RAIL2]) && $past(q.state) == ST_SEQ) |-> $past(q.seq) == RAIL2_TICKS)
        else $error("Rail two enabled at the wrong delay.");

    reset_release_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(cpu_reset_out_oe) |-> $past(pg3) && $past(q.rst_cnt) == RESET_TICKS - 8'h01)
        else $error("Reset released without rail three good.");

    hold_keeps_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (q.state == ST_RUN && hold) |=> q.state == ST_RUN)
        else $error("Run left while hold asserted.");

    hibernate_rail_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (q.state == ST_HIB) [*2] |-> rail_enable == RAIL1_ONLY)
        else $error("Hibernate rails wrong.");
endmodule
`default_nettype wire

// File: sim/pbs_partner.sv
// Regulator power-good and pull-up model for the far side of the sequencer.
`timescale 1ns/100ps
`default_nettype none
module pbs_partner
    import pbs_pkg::*;
(
    input wire logic mclk, // Clock.
    input wire logic [NUM_RAILS-1:0] rail_enable, // Regulator enables.
    input wire logic [NUM_RAILS-1:0] rail_fail, // Rails held out of regulation.
    input wire logic rst_o, // Reset drive level.
    input wire logic rst_oe, // Reset pull-down.
    input wire logic stat_o, // Status drive level.
    input wire logic stat_oe, // Status pull-down.
    input wire logic irq_o, // Interrupt drive level.
    input wire logic irq_oe, // Interrupt pull-down.
    output logic [NUM_RAILS-1:0] rail_pgood, // Power-good per rail.
    output logic rst_n, // Reset wire level.
    output logic stat_n, // Status wire level.
    output logic irq_n // Interrupt wire level.
);
    logic [NUM_RAILS-1:0] ramp1_q, ramp2_q, ramp3_q;
    // A rail reports good three cycles after its enable and drops at once when disabled.
    always_ff @(posedge mclk) begin
        ramp1_q <= rail_enable;
        ramp2_q <= ramp1_q & rail_enable;
        ramp3_q <= ramp2_q & rail_enable;
    end
    assign rail_pgood = ramp3_q & rail_enable & ~rail_fail;
    // Released open-drain lines rise through their pull-ups.
    assign rst_n = rst_oe ? rst_o : 1'b1;
    assign stat_n = stat_oe ? stat_o : 1'b1;
    assign irq_n = irq_oe ? irq_o : 1'b1;
endmodule
`default_nettype wire

// File: sim/test_pbs_sequencer.sv
// Self-checking bench for the push-button power sequencer.
`timescale 1ns/100ps
`default_nettype none
module test_pbs_sequencer
    import pbs_pkg::*;
;
    logic mclk = 1'b0, sys_rst = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic push_button_in_n = 1'b1, push_button_short_n = 1'b1, main_rail_hold = 1'b0;
    logic aux_rail_enable = 1'b0, standby_voltage_select = 1'b0, sys_voltage_low = 1'b0;
    logic [NUM_RAILS-1:0] rail_pgood, rail_enable, rail_fail = 7'h00;
    logic standby_select_out, cpu_reset_out_o, cpu_reset_out_oe, button_status_out_o;
    logic button_status_out_oe, interrupt_request_out_o, interrupt_request_out_oe;
    logic rst_n, stat_n, irq_n;
    logic [31:0] rd;
    int errors = 0;
    int checks = 0;
    int c1, c2, c3, c4;

    always #5 mclk = ~mclk;

    pbs_sequencer #(.TICK_CYCLES(17'h0000A), .RESET_TICKS(8'h06), .DEBOUNCE_TICKS(8'h02)) DUT (
        .mclk(mclk), .sys_rst(sys_rst),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .push_button_in_n(push_button_in_n),
        .push_button_short_n(push_button_short_n), .main_rail_hold(main_rail_hold),
        .aux_rail_enable(aux_rail_enable), .standby_voltage_select(standby_voltage_select),
        .rail_pgood(rail_pgood), .sys_voltage_low(sys_voltage_low), .rail_enable(rail_enable),
        .standby_select_out(standby_select_out), .cpu_reset_out_o(cpu_reset_out_o),
        .cpu_reset_out_oe(cpu_reset_out_oe), .button_status_out_o(button_status_out_o),
        .button_status_out_oe(button_status_out_oe), .interrupt_request_out_o(interrupt_request_out_o),
        .interrupt_request_out_oe(interrupt_request_out_oe));

    pbs_partner far_side (.mclk(mclk), .rail_enable(rail_enable), .rail_fail(rail_fail),
        .rst_o(cpu_reset_out_o), .rst_oe(cpu_reset_out_oe), .stat_o(button_status_out_o),
        .stat_oe(button_status_out_oe), .irq_o(interrupt_request_out_o), .irq_oe(interrupt_request_out_oe),
        .rail_pgood(rail_pgood), .rst_n(rst_n), .stat_n(stat_n), .irq_n(irq_n));

    task automatic end_sim();
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic check_range(input string nm, input int v, input int lo, input int hi);
        checks++;
        if (v < lo || v > hi) begin
            errors++;
            $display("wrong value %s expected %0d to %0d seen %0d", nm, lo, hi, v);
        end
    endtask

    task automatic guard(input logic ok);
        check("wait_done", 32'h1, {31'h0, ok});
        if (!ok) end_sim();
    endtask

    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic aw_hs, w_hs, b_hs;
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b_hs = 1'b0;
        n = 0;
        while (!b_hs && n < 50) begin
            @(negedge mclk);
            aw_hs = s_axi_awvalid & s_axi_awready;
            w_hs = s_axi_wvalid & s_axi_wready;
            b_hs = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge mclk);
            n++;
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (b_hs) s_axi_bready <= 1'b0;
        end
        @(posedge mclk);
        guard(b_hs);
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a);
        logic ar_hs, r_hs;
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r_hs = 1'b0;
        n = 0;
        while (!r_hs && n < 50) begin
            @(negedge mclk);
            ar_hs = s_axi_arvalid & s_axi_arready;
            r_hs = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge mclk);
            n++;
            if (ar_hs) s_axi_arvalid <= 1'b0;
            if (r_hs) s_axi_rready <= 1'b0;
        end
        @(posedge mclk);
        guard(r_hs);
    endtask

    // Kind 0 waits for a rail pattern, 1 for reset released, 2 for reset asserted.
    task automatic wait_until(input int what, input logic [NUM_RAILS-1:0] exp, output int cyc);
        logic hit;
        cyc = 0;
        hit = 1'b0;
        while (!hit && cyc < 400) begin
            @(negedge mclk);
            case (what)
                0: hit = (rail_enable === exp);
                1: hit = (rst_n === 1'b1);
                default: hit = (rst_n === 1'b0);
            endcase
            if (!hit) cyc++;
        end
        @(posedge mclk);
        guard(hit);
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        check("rst_idle", 32'h0, 32'(rst_n));
        axi_read(ADDR_UNMASK);
        check("unmask_reset", 32'h0, rd);
        axi_read(ADDR_CTRL);
        check("ctrl_reset", 32'h0, rd);
        axi_read(8'h0C);
        check("unmapped_resp", 32'(RESP_SLVERR), 32'(rsp));
        check("irq_idle", 32'h1, 32'(irq_n));
        // Short press released before the processor takes hold.
        push_button_in_n <= 1'b0;
        wait_until(0, 7'h04, c1);
        check("stat_pressed", 32'h0, 32'(stat_n));
        push_button_in_n <= 1'b1;
        wait_until(0, 7'h00, c1);
        check("stat_released", 32'h1, 32'(stat_n));
        repeat (40) @(posedge mclk);
        // Full boot with the processor taking hold.
        push_button_in_n <= 1'b0;
        wait_until(0, 7'h04, c1);
        wait_until(0, 7'h05, c1);
        check_range("rail1_delay", c1, 11, 29);
        wait_until(0, 7'h07, c2);
        check_range("rail2_delay", c1 + c2, 29, 51);
        check("rst_in_seq", 32'h0, 32'(rst_n));
        main_rail_hold <= 1'b1;
        aux_rail_enable <= 1'b1;
        wait_until(0, 7'h7F, c3);
        wait_until(1, 7'h00, c4);
        check_range("rst_timeout", c1 + c2 + c3 + c4, 47, 80);
        push_button_in_n <= 1'b1;
        repeat (60) @(posedge mclk);
        check("rails_held", 32'h7F, 32'(rail_enable));
        // Hard short acts as a manual reset.
        push_button_short_n <= 1'b0;
        push_button_in_n <= 1'b0;
        wait_until(2, 7'h00, c1);
        check_range("mr_assert", c1, 0, 5);
        repeat (90) @(posedge mclk);
        check("mr_held", 32'h0, 32'(rst_n));
        push_button_short_n <= 1'b1;
        push_button_in_n <= 1'b1;
        wait_until(1, 7'h00, c1);
        check_range("mr_timeout", c1, 44, 80);
        // Sleep and wake.
        aux_rail_enable <= 1'b0;
        wait_until(0, 7'h07, c1);
        standby_voltage_select <= 1'b1;
        repeat (5) @(posedge mclk);
        check("standby_voltage_select_on", 32'h1, 32'(standby_select_out));
        standby_voltage_select <= 1'b0;
        aux_rail_enable <= 1'b1;
        wait_until(0, 7'h7F, c1);
        check("standby_voltage_select_off", 32'h0, 32'(standby_select_out));
        // Interrupt sources unmasked one at a time; status confirms each source.
        axi_write(ADDR_UNMASK, 32'h1);
        check("wr_resp", 32'(RESP_OKAY), 32'(rsp));
        sys_voltage_low <= 1'b1;
        repeat (6) @(posedge mclk);
        check("irq_sys", 32'h0, 32'(irq_n));
        axi_read(ADDR_STATUS);
        check("status_sys", 32'h00037F01, rd);
        axi_write(ADDR_UNMASK, 32'h2);
        repeat (3) @(posedge mclk);
        check("irq_sys_masked", 32'h1, 32'(irq_n));
        rail_fail <= 7'h10;
        repeat (6) @(posedge mclk);
        check("irq_fault", 32'h0, 32'(irq_n));
        axi_read(ADDR_STATUS);
        check("status_fault", 32'h00037F03, rd);
        rail_fail <= 7'h00;
        sys_voltage_low <= 1'b0;
        repeat (6) @(posedge mclk);
        check("irq_clear", 32'h1, 32'(irq_n));
        axi_write(ADDR_UNMASK, 32'h0);
        // Hibernate entry and wake.
        axi_write(ADDR_CTRL, 32'h3);
        aux_rail_enable <= 1'b0;
        main_rail_hold <= 1'b0;
        wait_until(0, 7'h01, c1);
        axi_read(ADDR_CTRL);
        check("ctrl_kept", 32'h3, rd);
        push_button_in_n <= 1'b0;
        wait_until(0, 7'h05, c1);
        wait_until(0, 7'h07, c2);
        check_range("wake_rail2", c2, 29, 51);
        check("wake_rst", 32'h0, 32'(rst_n));
        main_rail_hold <= 1'b1;
        push_button_in_n <= 1'b1;
        axi_write(ADDR_CTRL, 32'h0);
        repeat (60) @(posedge mclk);
        check("wake_held", 32'h07, 32'(rail_enable));
        main_rail_hold <= 1'b0;
        wait_until(0, 7'h00, c1);
        end_sim();
    end
endmodule
`default_nettype wire
